/* logic/spc_top.sv */
/*
  System power, clock and reset controller: power modes, clock select
  and switch, clock monitor, frequency lock, reset causes, interrupts.
  Assumes pins synchronised here and interrupt lines in the MCLK domain.
*/
`timescale 1ns/1ps
// What this block does
// - Mode field: 00 run, 01 standby, 10 sleep, 11 deep
// - Standby halts core, exits on enabled interrupt
// - Sleep powers down core and most peripherals
// - Sleep keeps each external RAM bank per setting
// - Sleep exits on port or controller interrupt
// - Deepest mode keeps only four scratch bytes
// - Deepest mode exits only on wake pin low
// - System clock picks one of four sources
// - Power-of-two divide, reset to fast RC halved
// - Glitch-free switch takes twice both periods
// - Switch waits for oscillator, status readable
// - Clock monitor reverts select on missing edges
// - Frequency lock trims oscillator, holds without reference
// - Fetch restarts at address zero after reset
// - Core reset on pin, sleep or deep wake, watchdog, software
// - Last reset cause readable in power control
// - Twenty-two sources, each enable and priority
// - Vectors at 0x0003 plus eight per source
// - Writing one to reset bit resets core
module spc_top
  import spc_pkg::*;
#(
  parameter int P_LSX_CYC = (MCLK_KHZ + F_LSX_KHZ - 1) / F_LSX_KHZ,
  parameter int P_LPO_CYC = (MCLK_KHZ + F_LPO_KHZ - 1) / F_LPO_KHZ
)
(
  input  wire logic             MCLK,
  input  wire logic             RESET,
  input  wire logic [4:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR_STB,
  input  wire logic             RD_STB,
  output logic      [7:0]       RDATA,
  input  wire logic             RESET_N_PIN,
  input  wire logic             WAKE_PIN,
  input  wire logic             SYSCLK_MON,
  input  wire logic [1:0]       OSC_OK,
  input  wire logic             HRC_TICK,
  input  wire logic             REF_TICK,
  input  wire logic             WDOG_EXPIRE,
  input  wire logic [IRQ_N-1:0] IRQ_REQ,
  output logic                  CORE_RESET,
  output logic                  CORE_HALT,
  output logic                  PERIPH_PWR_EN,
  output logic                  PERIPH_RESET,
  output logic      [1:0]       XRAM_PWR,
  output logic                  TRX_PWR_EN,
  output logic      [1:0]       CLK_SEL,
  output logic      [2:0]       CLK_DIV,
  output logic                  CLK_BUSY,
  output logic      [7:0]       FLL_TRIM,
  output logic      [15:0]      START_ADDR,
  output logic                  IRQ_VALID,
  output logic                  IRQ_HIGH,
  output logic      [15:0]      IRQ_VECTOR
);
  typedef enum logic [1:0] {PS_RUN, PS_STBY, PS_SLP, PS_DEEP} spc_pwr_t;
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_SWAP} spc_csw_t;

  spc_pwr_t         pst_q;
  spc_csw_t         cst_q;
  logic [6:0]       pin_s;
  logic             rstn_s;
  logic             wake_s;
  logic             sysclk_s;
  logic [1:0]       osc_s;
  logic             hrc_s;
  logic             ref_s;
  logic             rstn_last_q;
  logic [2:0]       cause_q;
  logic [3:0]       rst_cnt_q;
  logic [1:0]       req_src_q;
  logic [2:0]       req_div_q;
  logic [15:0]      sw_cnt_q;
  logic [1:0]       ret_q;
  logic [7:0]       mon_q;
  logic [3:0]       mon_pre_q;
  logic [7:0]       mon_cnt_q;
  logic             sysclk_last_q;
  logic             mon_trip;
  logic             fll_en_q;
  logic [7:0]       flt_q;
  logic [3:0]       ref_cnt_q;
  logic [8:0]       hrc_cnt_q;
  logic             ref_last_q;
  logic             hrc_last_q;
  logic [23:0]      ien_q;
  logic [23:0]      ipr_q;
  logic [7:0]       scr_q [0:3];
  logic [7:0]       rd_d;
  logic             sw_rst;
  logic             stby_wake;
  logic             slp_wake;
  logic             new_ok;

  // Register write hit
  function automatic logic wr_hit(input logic [4:0] a);
    wr_hit = WR_STB && (ADDR == a);
  endfunction

  // Oscillator period in MCLK cycles, used for the switch time
  function automatic logic [15:0] src_cyc(input logic [1:0] s);
    case (s)
      SRC_RFX: src_cyc = RFX_CYC;
      SRC_LSX: src_cyc = 16'(P_LSX_CYC);
      SRC_HRC: src_cyc = HRC_CYC;
      default: src_cyc = 16'(P_LPO_CYC);
    endcase
  endfunction

  // Pins from outside the clock domain
  spc_sync #(.W(7), .INIT(7'h03)) u_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   ({REF_TICK, HRC_TICK, OSC_OK, SYSCLK_MON, WAKE_PIN, RESET_N_PIN}),
    .q   (pin_s)
  );
  assign rstn_s   = pin_s[0];
  assign wake_s   = pin_s[1];
  assign sysclk_s = pin_s[2];
  assign osc_s    = pin_s[4:3];
  assign hrc_s    = pin_s[5];
  assign ref_s    = pin_s[6];

  // Interrupt selection and vectors
  spc_irq #(.N(IRQ_N)) u_irq (
    .clk     (MCLK),
    .rst     (RESET),
    .req     (IRQ_REQ),
    .en      (ien_q[IRQ_N-1:0]),
    .prio    (ipr_q[IRQ_N-1:0]),
    .valid_q (IRQ_VALID),
    .high_q  (IRQ_HIGH),
    .vec_q   (IRQ_VECTOR)
  );

  // Wake conditions
  assign sw_rst    = wr_hit(A_PWR) && WDATA[F_SWRST] && pst_q == PS_RUN;
  assign stby_wake = |(IRQ_REQ & ien_q[IRQ_N-1:0]);
  assign slp_wake  = |(IRQ_REQ & ien_q[IRQ_N-1:0] & SLP_WAKE_MASK);

  // Power mode sequencer; new modes only while the core runs
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      pst_q <= PS_RUN;
    else
      case (pst_q)
        PS_RUN:
          if (wr_hit(A_PWR) && !WDATA[F_SWRST])
            case (WDATA[1:0])
              M_STBY:  pst_q <= PS_STBY;
              M_SLP:   pst_q <= PS_SLP;
              M_DEEP:  pst_q <= PS_DEEP;
              default: pst_q <= PS_RUN;
            endcase
        PS_STBY: if (stby_wake) pst_q <= PS_RUN;
        PS_SLP:  if (slp_wake) pst_q <= PS_RUN;
        PS_DEEP: if (!wake_s) pst_q <= PS_RUN;
        default: pst_q <= PS_RUN;
      endcase
  end

  // Power outputs follow the mode
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      CORE_HALT     <= 1'b0;
      PERIPH_PWR_EN <= 1'b1;
      PERIPH_RESET  <= 1'b0;
      XRAM_PWR      <= 2'h3;
      TRX_PWR_EN    <= 1'b1;
    end
    else
    begin
      CORE_HALT     <= pst_q != PS_RUN;
      PERIPH_PWR_EN <= pst_q == PS_RUN || pst_q == PS_STBY;
      PERIPH_RESET  <= pst_q == PS_SLP || pst_q == PS_DEEP;
      case (pst_q)
        PS_SLP:  XRAM_PWR <= ret_q;
        PS_DEEP: XRAM_PWR <= 2'h0;
        default: XRAM_PWR <= 2'h3;
      endcase
      TRX_PWR_EN    <= pst_q != PS_DEEP;
    end
  end

  // Core reset pulse and its cause; pin held low keeps it in reset
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      rstn_last_q <= 1'b1;
      cause_q     <= C_POR;
      rst_cnt_q   <= CORE_RST_CYC;
      CORE_RESET  <= 1'b1;
      START_ADDR  <= PC_RST;
    end
    else
    begin
      rstn_last_q <= rstn_s;
      if (!rstn_s)
        rst_cnt_q <= CORE_RST_CYC;
      else if (rstn_s && !rstn_last_q)
      begin
        cause_q   <= C_PIN;
        rst_cnt_q <= CORE_RST_CYC;
      end
      else if (pst_q == PS_SLP && slp_wake)
      begin
        cause_q   <= C_SLP;
        rst_cnt_q <= CORE_RST_CYC;
      end
      else if (pst_q == PS_DEEP && !wake_s)
      begin
        cause_q   <= C_DEEP;
        rst_cnt_q <= CORE_RST_CYC;
      end
      else if (WDOG_EXPIRE)
      begin
        cause_q   <= C_WDOG;
        rst_cnt_q <= CORE_RST_CYC;
      end
      else if (sw_rst)
      begin
        cause_q   <= C_SW;
        rst_cnt_q <= CORE_RST_CYC;
      end
      else if (rst_cnt_q != 4'h0)
        rst_cnt_q <= rst_cnt_q - 4'h1;
      CORE_RESET <= !rstn_s || rst_cnt_q != 4'h0;
      START_ADDR <= PC_RST;
    end
  end

  // Clock monitor: count idle units since the last sysclk edge
  assign mon_trip = mon_q != 8'h00 && mon_cnt_q == mon_q;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      sysclk_last_q <= 1'b0;
      mon_pre_q     <= 4'h0;
      mon_cnt_q     <= 8'h00;
    end
    else
    begin
      sysclk_last_q <= sysclk_s;
      mon_pre_q     <= mon_pre_q + 4'h1;
      if (sysclk_s != sysclk_last_q || mon_q == 8'h00 || mon_trip)
      begin
        mon_pre_q <= 4'h0;
        mon_cnt_q <= 8'h00;
      end
      else if (mon_pre_q == MON_UNIT_CYC)
        mon_cnt_q <= mon_cnt_q + 8'h01;
    end
  end

  // Requested source ready: crystals report, internal ones at once
  assign new_ok = req_src_q == SRC_RFX ? osc_s[0] :
                  req_src_q == SRC_LSX ? osc_s[1] : 1'b1;

  // Clock switch sequencer; a new request restarts it in any state; a monitor trip wins
  always_ff @(posedge MCLK)
  begin
    if (RESET || mon_trip)
    begin
      req_src_q <= CLK_SRC_RST;
      req_div_q <= CLK_DIV_RST;
      CLK_SEL   <= CLK_SRC_RST;
      CLK_DIV   <= CLK_DIV_RST;
      CLK_BUSY  <= 1'b0;
      sw_cnt_q  <= 16'h0000;
      cst_q     <= CS_IDLE;
    end
    else if (wr_hit(A_CLK))
    begin
      req_src_q <= WDATA[1:0];
      req_div_q <= WDATA[4:2];
      CLK_BUSY  <= 1'b1;
      cst_q     <= CS_WAIT;
    end
    else
      case (cst_q)
        CS_WAIT:
          if (new_ok)
          begin
            sw_cnt_q <= 16'((src_cyc(CLK_SEL) + src_cyc(req_src_q)) << 1);
            cst_q    <= CS_SWAP;
          end
        CS_SWAP:
          if (sw_cnt_q <= 16'h0001)
          begin
            CLK_SEL  <= req_src_q;
            CLK_DIV  <= req_div_q;
            CLK_BUSY <= 1'b0;
            cst_q    <= CS_IDLE;
          end
          else
            sw_cnt_q <= sw_cnt_q - 16'h0001;
        default: cst_q <= CS_IDLE;
      endcase
  end

  // Frequency lock: count RC ticks over sixteen reference ticks
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ref_last_q <= 1'b0;
      hrc_last_q <= 1'b0;
      ref_cnt_q  <= 4'h0;
      hrc_cnt_q  <= 9'h000;
      FLL_TRIM   <= TRM_RST;
    end
    else
    begin
      ref_last_q <= ref_s;
      hrc_last_q <= hrc_s;
      if (!fll_en_q || !osc_s[0])
      begin
        ref_cnt_q <= 4'h0;
        hrc_cnt_q <= 9'h000;
      end
      else if (ref_s && !ref_last_q)
      begin
        ref_cnt_q <= ref_cnt_q + 4'h1;
        if (ref_cnt_q == 4'hf)
        begin
          hrc_cnt_q <= 9'h000;
          if (hrc_cnt_q > {1'b0, flt_q} && FLL_TRIM != 8'h00)
            FLL_TRIM <= FLL_TRIM - 8'h01;
          else if (hrc_cnt_q < {1'b0, flt_q} && FLL_TRIM != 8'hff)
            FLL_TRIM <= FLL_TRIM + 8'h01;
        end
      end
      else if (hrc_s && !hrc_last_q && hrc_cnt_q != 9'h1ff)
        hrc_cnt_q <= hrc_cnt_q + 9'h001;
    end
  end

  // Software registers; scratch bytes never lose power
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ret_q    <= 2'h3;
      mon_q    <= MON_RST;
      fll_en_q <= 1'b0;
      flt_q    <= FLT_RST;
      ien_q    <= 24'h000000;
      ipr_q    <= 24'h000000;
      for (int i = 0; i < 4; i++)
        scr_q[i] <= 8'h00;
    end
    else
    begin
      if (wr_hit(A_RET))
        ret_q <= WDATA[1:0];
      if (wr_hit(A_MON))
        mon_q <= WDATA;
      if (wr_hit(A_FLC))
        fll_en_q <= WDATA[0];
      if (wr_hit(A_FLT))
        flt_q <= WDATA;
      for (int i = 0; i < 3; i++)
      begin
        if (wr_hit(A_IEN + 5'(i)))
          ien_q[8*i +: 8] <= WDATA;
        if (wr_hit(A_IPR + 5'(i)))
          ipr_q[8*i +: 8] <= WDATA;
      end
      for (int i = 0; i < 4; i++)
        if (wr_hit(A_SCR + 5'(i)))
          scr_q[i] <= WDATA;
    end
  end

  // Read mux
  always_comb
  begin
    case (ADDR)
      A_PWR:        rd_d = {1'b0, cause_q, 2'b00, pst_q};
      A_CLK:        rd_d = {3'b000, req_div_q, req_src_q};
      A_CST:        rd_d = {3'b000, cst_q == CS_WAIT, CLK_BUSY, CLK_DIV[0], CLK_SEL};
      A_RET:        rd_d = {6'h00, ret_q};
      A_MON:        rd_d = mon_q;
      A_FLC:        rd_d = {7'h00, fll_en_q};
      A_FLT:        rd_d = flt_q;
      A_TRM:        rd_d = FLL_TRIM;
      A_IEN:        rd_d = ien_q[7:0];
      A_IEN + 5'h1: rd_d = ien_q[15:8];
      A_IEN + 5'h2: rd_d = ien_q[23:16];
      A_IPR:        rd_d = ipr_q[7:0];
      A_IPR + 5'h1: rd_d = ipr_q[15:8];
      A_IPR + 5'h2: rd_d = ipr_q[23:16];
      A_SCR:        rd_d = scr_q[0];
      A_SCR + 5'h1: rd_d = scr_q[1];
      A_SCR + 5'h2: rd_d = scr_q[2];
      A_SCR + 5'h3: rd_d = scr_q[3];
      default:      rd_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      RDATA <= 8'h00;
    else
      RDATA <= RD_STB ? rd_d : 8'h00;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence seq_swrst_wr;
    WR_STB && ADDR == A_PWR && WDATA[F_SWRST] && pst_q == PS_RUN;
  endsequence
  sequence seq_core_rst_end;
    CORE_RESET ##1 !CORE_RESET;
  endsequence

  AST_STBY_HALT: assert property (pst_q == PS_STBY |=> CORE_HALT)
    else $error("core not halted in standby");
  AST_SLP_PWR: assert property (pst_q == PS_SLP |=> !PERIPH_PWR_EN && PERIPH_RESET)
    else $error("peripherals powered in sleep");
  AST_SLP_RET: assert property (pst_q == PS_SLP |=> XRAM_PWR == $past(ret_q))
    else $error("RAM bank power not per retention");
  AST_DEEP_HOLD: assert property (pst_q == PS_DEEP && wake_s |=> pst_q == PS_DEEP)
    else $error("left deepest mode without wake pin");
  AST_SWRST: assert property (seq_swrst_wr |=> ##1 CORE_RESET && cause_q == C_SW)
    else $error("software reset not taken");
  AST_START: assert property (seq_core_rst_end |-> START_ADDR == PC_RST)
    else $error("start address not zero");
  AST_MON_REVERT: assert property (mon_trip |=> CLK_SEL == SRC_HRC && !CLK_BUSY)
    else $error("monitor did not revert clock");
  AST_VEC: assert property (IRQ_VALID |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR <= 16'h00ab)
    else $error("vector off grid");
  AST_SWITCH: assert property (cst_q == CS_WAIT && new_ok && !WR_STB && !mon_trip |=> cst_q == CS_SWAP && sw_cnt_q >= 16'h0004)
    else $error("switch delay not loaded");
endmodule

/* logic/spc_pkg.sv */
/*
  Shared constants of the system power, clock and reset controller:
  register indices, field positions, reset values, encodings, timing.
  Assumes an 8-bit register port and MCLK at 100 MHz.
*/
package spc_pkg;
  // Register indices (byte-wide registers)
  localparam logic [4:0] A_PWR = 5'h00;
  localparam logic [4:0] A_CLK = 5'h01;
  localparam logic [4:0] A_CST = 5'h02;
  localparam logic [4:0] A_RET = 5'h03;
  localparam logic [4:0] A_MON = 5'h04;
  localparam logic [4:0] A_FLC = 5'h05;
  localparam logic [4:0] A_FLT = 5'h06;
  localparam logic [4:0] A_TRM = 5'h07;
  localparam logic [4:0] A_IEN = 5'h08;
  localparam logic [4:0] A_IPR = 5'h0b;
  localparam logic [4:0] A_SCR = 5'h10;
  // Field positions in power_control_reg
  localparam int F_SWRST = 2;
  localparam int F_CAUSE = 4;
  // Power mode encodings
  localparam logic [1:0] M_RUN  = 2'h0;
  localparam logic [1:0] M_STBY = 2'h1;
  localparam logic [1:0] M_SLP  = 2'h2;
  localparam logic [1:0] M_DEEP = 2'h3;
  // Clock sources
  localparam logic [1:0] SRC_RFX = 2'h0;
  localparam logic [1:0] SRC_LSX = 2'h1;
  localparam logic [1:0] SRC_HRC = 2'h2;
  localparam logic [1:0] SRC_LPO = 2'h3;
  localparam logic [1:0] CLK_SRC_RST = SRC_HRC;
  localparam logic [2:0] CLK_DIV_RST = 3'h1;
  // Reset causes
  localparam logic [2:0] C_POR  = 3'h0;
  localparam logic [2:0] C_PIN  = 3'h1;
  localparam logic [2:0] C_SLP  = 3'h2;
  localparam logic [2:0] C_DEEP = 3'h3;
  localparam logic [2:0] C_WDOG = 3'h4;
  localparam logic [2:0] C_SW   = 3'h5;
  // Oscillator frequencies and clock rate
  localparam int MCLK_KHZ  = 100000;
  localparam int F_RFX_KHZ = 16000;
  localparam int F_LSX_KHZ = 32;
  localparam int F_HRC_KHZ = 20000;
  localparam int F_LPO_KHZ = 10;
  localparam logic [15:0] RFX_CYC = 16'((MCLK_KHZ + F_RFX_KHZ - 1) / F_RFX_KHZ);
  localparam logic [15:0] HRC_CYC = 16'((MCLK_KHZ + F_HRC_KHZ - 1) / F_HRC_KHZ);
  // Core reset pulse
  localparam int T_CORE_RST_NS = 40;
  localparam logic [3:0] CORE_RST_CYC = 4'((T_CORE_RST_NS * MCLK_KHZ + 999999) / 1000000);
  // Interrupts
  localparam int IRQ_N = 22;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [IRQ_N-1:0] SLP_WAKE_MASK = 22'h00000f;
  // Clock monitor and frequency lock
  localparam logic [7:0] MON_RST = 8'hff;
  localparam logic [3:0] MON_UNIT_CYC = 4'hf;
  localparam logic [7:0] FLT_RST = 8'h14;
  localparam logic [7:0] TRM_RST = 8'h80;
endpackage

/* logic/spc_sync.sv */
/*
  Three-stage synchroniser for a group of asynchronous levels.
  Assumes inputs that change slowly against MCLK.
*/
`timescale 1ns/1ps
module spc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= INIT;
    else
      q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & q);
  end
endmodule

/* logic/spc_irq.sv */
/*
  Interrupt selector: picks the pending enabled source, high priority
  first and lowest number next, and gives its vector address.
  Assumes request lines already in the MCLK domain.
*/
`timescale 1ns/1ps
module spc_irq
  import spc_pkg::*;
#(
  parameter int N = IRQ_N
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] en,
  input  wire logic [N-1:0] prio,
  output logic              valid_q,
  output logic              high_q,
  output logic [15:0]       vec_q
);
  logic [15:0] vec_d;
  logic        valid_d;
  logic        high_d;

  // Vector spacing of eight bytes from the base
  function automatic logic [15:0] vec_of(input int idx);
    vec_of = VEC_BASE + 16'(idx) * VEC_STEP;
  endfunction

  // Scan downward so that the lowest number wins inside a level
  always_comb
  begin
    vec_d   = 16'h0000;
    valid_d = 1'b0;
    high_d  = 1'b0;
    for (int i = N - 1; i >= 0; i--)
      if (req[i] && en[i] && !prio[i])
      begin
        vec_d   = vec_of(i);
        valid_d = 1'b1;
      end
    for (int i = N - 1; i >= 0; i--)
      if (req[i] && en[i] && prio[i])
      begin
        vec_d   = vec_of(i);
        valid_d = 1'b1;
        high_d  = 1'b1;
      end
  end

  // Registered result
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
      high_q  <= 1'b0;
      vec_q   <= 16'h0000;
    end
    else
    begin
      valid_q <= valid_d;
      high_q  <= high_d;
      vec_q   <= vec_d;
    end
  end
endmodule

/* verif/spc_top_tb.sv */
/*
  Self-checking bench for spc_top: power modes, core resets, clock
  switch and monitor, frequency lock, interrupts over the register port.
  Assumes spc_pkg and slow-oscillator periods shortened to 8 cycles.
*/
`timescale 1ns/1ps
module spc_top_tb;
  import spc_pkg::*;
  logic             MCLK, RESET, WR_STB, RD_STB, RESET_N_PIN, WAKE_PIN, WDOG_EXPIRE;
  logic             SYSCLK_MON, HRC_TICK, REF_TICK, mon_run, ref_run;
  logic             CORE_RESET, CORE_HALT, PERIPH_PWR_EN, PERIPH_RESET, TRX_PWR_EN;
  logic             CLK_BUSY, IRQ_VALID, IRQ_HIGH;
  logic [4:0]       ADDR;
  logic [7:0]       WDATA, RDATA, FLL_TRIM, rv, t0;
  logic [1:0]       OSC_OK, XRAM_PWR, CLK_SEL, img_div;
  logic [2:0]       CLK_DIV;
  logic [15:0]      START_ADDR, IRQ_VECTOR;
  logic [IRQ_N-1:0] IRQ_REQ;
  int               mismatches, checked, n;

  spc_top #(.P_LSX_CYC(8), .P_LPO_CYC(8)) uut (.MCLK, .RESET, .ADDR, .WDATA, .WR_STB,
    .RD_STB, .RDATA, .RESET_N_PIN, .WAKE_PIN, .SYSCLK_MON, .OSC_OK, .HRC_TICK, .REF_TICK,
    .WDOG_EXPIRE, .IRQ_REQ, .CORE_RESET, .CORE_HALT, .PERIPH_PWR_EN, .PERIPH_RESET,
    .XRAM_PWR, .TRX_PWR_EN, .CLK_SEL, .CLK_DIV, .CLK_BUSY, .FLL_TRIM, .START_ADDR,
    .IRQ_VALID, .IRQ_HIGH, .IRQ_VECTOR);

  // 100 MHz clock
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Stand-in images of system clock and reference; stopping the clock image is a fault, stopping the reference makes the lock hold
  // Toggled every fourth cycle: the pin filter drops a level held one cycle
  always @(posedge MCLK)
  begin
    img_div <= img_div + 2'h1;
    if (img_div == 2'h3 && mon_run) SYSCLK_MON <= ~SYSCLK_MON;
    if (img_div == 2'h3 && ref_run) REF_TICK <= ~REF_TICK;
  end

  task cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task close_out;
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge MCLK);
    WR_STB <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge MCLK);
    RD_STB <= 1'b0;
    #1 d = RDATA;
  endtask

  function automatic logic pick(int w);
    case (w)
      0: return CORE_RESET;
      1: return CLK_BUSY;
      2: return CORE_HALT;
      default: return CLK_SEL == SRC_HRC;
    endcase
  endfunction

  // Bounded wait; running out ends the run rather than hanging
  task wt(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim)
    begin
      @(posedge MCLK);
      #1 n++;
    end
    if (n >= lim)
    begin
      mismatches++;
      $display("[FAIL] wait %0d expected %b seen timeout", w, v);
      close_out;
    end
  endtask

  // One core reset pulse, then fetch address, mode and recorded cause
  task core_rst(input logic [2:0] c);
    wt(0, 1'b1, 40);
    wt(0, 1'b0, 40);
    cmp("core_reset_len", 1, n >= 4);
    cmp("start_addr", PC_RST, START_ADDR);
    rd(A_PWR, rv);
    cmp("mode", M_RUN, rv[1:0]);
    cmp("cause", c, rv[6:4]);
  endtask

  task irq(input logic [IRQ_N-1:0] r, input logic v, input logic [15:0] vec, input logic hi);
    @(posedge MCLK);
    IRQ_REQ <= r;
    repeat (2) @(posedge MCLK);
    #1 cmp("irq_valid", v, IRQ_VALID);
    if (v)
    begin
      cmp("irq_vector", vec, IRQ_VECTOR);
      cmp("irq_high", hi, IRQ_HIGH);
    end
  endtask

  // Helper for power-mode output snapshots
  task pw(input logic [7:0] e);
    repeat (20) @(posedge MCLK);
    #1 cmp("power_outs", e, {CORE_HALT, PERIPH_PWR_EN, PERIPH_RESET, TRX_PWR_EN, XRAM_PWR});
  endtask

  initial
  begin
    RESET = 1'b1;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    ADDR = 5'h00;
    WDATA = 8'h00;
    RESET_N_PIN = 1'b1;
    WAKE_PIN = 1'b1;
    WDOG_EXPIRE = 1'b0;
    SYSCLK_MON = 1'b0;
    HRC_TICK = 1'b0;
    REF_TICK = 1'b0;
    OSC_OK = 2'h0;
    IRQ_REQ = '0;
    mon_run = 1'b1;
    img_div = 2'h0;
    ref_run = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge MCLK);
    RESET <= 1'b0;
    #1 cmp("clk_sel", CLK_SRC_RST, CLK_SEL);
    cmp("clk_div", CLK_DIV_RST, CLK_DIV);
    core_rst(C_POR);
    rd(5'h1f, rv);
    cmp("unmapped", 8'h00, rv);
    // Sources 0, 5, 21 enabled; 21 high priority
    wr(A_IEN, 8'h21);
    wr(5'h0a, 8'h20);
    wr(5'h0d, 8'h20);
    irq(22'h000002, 1'b0, 16'h0000, 1'b0);
    irq(22'h000021, 1'b1, 16'h0003, 1'b0);
    irq(22'h000020, 1'b1, 16'h002b, 1'b0);
    irq(22'h200021, 1'b1, 16'h00ab, 1'b1);
    irq(22'h000000, 1'b0, 16'h0000, 1'b0);
    // Standby keeps peripherals; any enabled source resumes without reset
    wr(A_PWR, {6'h00, M_STBY});
    pw(8'h37);
    rd(A_PWR, rv);
    cmp("mode", M_STBY, rv[1:0]);
    IRQ_REQ <= 22'h000020;
    wt(2, 1'b0, 10);
    cmp("no_core_reset", 1'b0, CORE_RESET);
    IRQ_REQ <= '0;
    // Sleep ignores sources outside the wake mask
    wr(A_RET, 8'h01);
    wr(A_PWR, {6'h00, M_SLP});
    IRQ_REQ <= 22'h000020;
    pw(8'h2d);
    IRQ_REQ <= 22'h000001;
    core_rst(C_SLP);
    IRQ_REQ <= '0;
    // Deepest mode wakes only on the pin; scratch survives
    wr(A_SCR, 8'h5a);
    wr(A_PWR, {6'h00, M_DEEP});
    IRQ_REQ <= 22'h000001;
    pw(8'h28);
    WAKE_PIN <= 1'b0;
    core_rst(C_DEEP);
    WAKE_PIN <= 1'b1;
    IRQ_REQ <= '0;
    rd(A_SCR, rv);
    cmp("scratch", 8'h5a, rv);
    RESET_N_PIN <= 1'b0;
    repeat (10) @(posedge MCLK);
    RESET_N_PIN <= 1'b1;
    core_rst(C_PIN);
    @(posedge MCLK);
    WDOG_EXPIRE <= 1'b1;
    @(posedge MCLK);
    WDOG_EXPIRE <= 1'b0;
    core_rst(C_WDOG);
    wr(A_PWR, 8'h04);
    core_rst(C_SW);
    // Switch to low-power oscillator, then to a crystal not yet running
    wr(A_CLK, 8'h03);
    wt(1, 1'b1, 4);
    wt(1, 1'b0, 300);
    cmp("switch_len", 1, n >= 2 * (HRC_CYC + 8) - 2);
    cmp("clk_sel_div", 5'h03, {CLK_DIV, CLK_SEL});
    wr(A_CLK, 8'h08);
    repeat (60) @(posedge MCLK);
    rd(A_CST, rv);
    cmp("switch_wait", 2'h3, rv[4:3]);
    OSC_OK <= 2'h1;
    wt(1, 1'b0, 300);
    cmp("clk_sel_div", 5'h08, {CLK_DIV, CLK_SEL});
    // Frequency lock: no RC edges, so trim must climb, then hold
    ref_run <= 1'b1;
    wr(A_FLC, 8'h01);
    repeat (300) @(posedge MCLK);
    #1 cmp("trim_up", 1, FLL_TRIM > TRM_RST);
    ref_run <= 1'b0;
    repeat (10) @(posedge MCLK);
    t0 = FLL_TRIM;
    repeat (100) @(posedge MCLK);
    #1 cmp("trim_held", t0, FLL_TRIM);
    // Stalled system clock reverts to the RC default
    wr(A_MON, 8'h01);
    repeat (40) @(posedge MCLK);
    #1 cmp("mon_quiet", SRC_RFX, CLK_SEL);
    mon_run <= 1'b0;
    wt(3, 1'b1, 200);
    cmp("clk_div", CLK_DIV_RST, CLK_DIV);
    close_out;
  end
endmodule
